/* File: bcs_sequencer.sv */
// Bus cycle sequencer for block compare, branch, exchange, halt and mode instructions
// Function
// RL1: Every instruction opens with a three-state opcode fetch, read, memory request, fetch and first-fetch low, write and I/O request high.
// RL2: In an idle state all strobes, halt and first-fetch are high and the data bus is released.
// RL3: An unfinished repeating compare fetches two opcodes, reads memory, then spends five idle states.
// RL4: A finished repeating compare ends after the memory read and three idle states.
// RL5: A taken decrement-and-branch runs fetch, one idle, displacement read, then two more idle states.
// RL6: After the idle state following the decrement-and-branch fetch, bus, refresh and DMA requests are not granted; the code enforces it only when taken.
// RL7: The interrupt-enable instruction is one fetch cycle and the interrupt request is not sampled at its end.
// RL8: Each state lasts one clock and cycles follow without gaps unless wait or bus requests intervene.
module bcs_sequencer
    import bcs_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Instruction request from the decoder
    input  wire logic       instrStart,
    input  bcs_instr_t      instrKind,
    input  wire logic       instrFinish,
    output logic            instrReady,
    output logic            instrDone,
    output logic            intSample,
    // Bus pins from outside
    input  wire logic       waitReqN,
    input  wire logic       busReq,
    input  wire logic       resumeReq,
    // Bus strobes
    output logic            rdN,
    output logic            wrN,
    output logic            memory_request_n,
    output logic            io_request_n,
    output logic            opcode_fetch_cycle_n,
    output logic            haltN,
    output logic            first_fetch_status,
    output logic            dataOe,
    output logic            busAck
);

    typedef enum logic [2:0] {PH_REST, PH_T1, PH_T2, PH_T3, PH_TI, PH_HOLD} bcs_phase_t;

    bcs_phase_t        phase_q, phase_d;
    bcs_cycle_t        cyc_q, cyc_d;
    bcs_instr_t        kind_q;
    logic [STEP_W-1:0] step_q, step_d;
    logic              done_q, ignore_q, ignore_d;
    logic [1:0]        waitSync_q, busSync_q, resumeSync_q;
    bcs_strobe_t       strobe_q, strobe_d;
    logic              ready_q, instrDone_q, intSample_q, busAck_q;

    bcs_step_if stepIf ();
    bcs_step_table uTable (.tbl(stepIf.table_side));

    // Pins are asynchronous to ref_clk, so only the second stage is read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            waitSync_q   <= 2'h3;
            busSync_q    <= 2'h0;
            resumeSync_q <= 2'h0;
        end else begin
            waitSync_q   <= {waitSync_q[0], waitReqN};
            busSync_q    <= {busSync_q[0], busReq};
            resumeSync_q <= {resumeSync_q[0], resumeReq};
        end
    end

    function automatic bcs_phase_t phaseFor(input bcs_cycle_t c);
        case (c)
            C_IDLE:  return PH_TI;
            C_END:   return PH_REST;
            default: return PH_T1;
        endcase
    endfunction

    wire waitS      = waitSync_q[1];
    wire busS       = busSync_q[1];
    wire resumeS    = resumeSync_q[1];
    wire startTake  = (phase_q == PH_REST) && instrStart && !busS;
    wire cycleEnd   = (phase_q == PH_T3) || (phase_q == PH_TI);
    wire haltExit   = (cyc_q == C_HALTF) && resumeS;
    wire haltStay   = (cyc_q == C_HALTF);
    wire instrEnd   = cycleEnd && ((stepIf.cycle == C_END) || haltExit);
    wire djnzTiEnd  = (phase_q == PH_TI) && (kind_q == K_DECREMENT_BRANCH_NONZERO) && (step_q == STEP_DECREMENT_BRANCH_NONZERO_TI)
                      && !done_q;
    wire grantMid   = (phase_q == PH_TI) && busS && !ignore_q && !djnzTiEnd && !instrEnd; // RL6
    wire intAllowed = (kind_q != K_EI) && (kind_q != K_DI); // RL7

    assign stepIf.kind = startTake ? instrKind : kind_q;
    assign stepIf.done = startTake ? instrFinish : done_q;
    // Step is parked in halt so a long halt never wraps back to a first fetch
    assign stepIf.step = startTake ? '0 : haltStay ? step_q : STEP_W'(step_q + 1'b1);

    always_comb begin
        phase_d  = phase_q;
        cyc_d    = cyc_q;
        step_d   = step_q;
        ignore_d = ignore_q || djnzTiEnd; // RL6
        case (phase_q)
            PH_REST: begin
                if (busS) begin
                    phase_d = PH_HOLD;
                    cyc_d   = C_END;
                end else if (startTake) begin
                    step_d  = '0;
                    cyc_d   = stepIf.cycle;
                    phase_d = phaseFor(stepIf.cycle); // RL1
                end
            end
            PH_T1:   phase_d = PH_T2; // RL8
            PH_T2:   phase_d = waitS ? PH_T3 : PH_T2;
            PH_HOLD: begin
                if (!busS) phase_d = phaseFor(cyc_q);
            end
            default: phase_d = phase_q;
        endcase
        if (cycleEnd) begin
            if (instrEnd) begin
                phase_d  = PH_REST;
                cyc_d    = C_END;
                ignore_d = 1'b0;
            end else begin
                step_d  = stepIf.step;
                cyc_d   = stepIf.cycle;
                phase_d = grantMid ? PH_HOLD : phaseFor(stepIf.cycle); // RL8
            end
        end
    end

    // Strobes follow the cycle type only inside T1..T3; rest and hold release all
    wire inBusCycle = (phase_d == PH_T1) || (phase_d == PH_T2) || (phase_d == PH_T3);
    assign strobe_d = inBusCycle ? strobesOf(cyc_d) : STROBE_REST; // RL2

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_q  <= PH_REST;
            cyc_q    <= C_END;
            step_q   <= '0;
            kind_q   <= K_CPL;
            done_q   <= 1'b0;
            ignore_q <= 1'b0;
        end else begin
            phase_q  <= phase_d;
            cyc_q    <= cyc_d;
            step_q   <= step_d;
            ignore_q <= ignore_d;
            if (startTake) begin
                kind_q <= instrKind;
                done_q <= instrFinish;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strobe_q    <= STROBE_REST;
            ready_q     <= 1'b0;
            instrDone_q <= 1'b0;
            intSample_q <= 1'b0;
            busAck_q    <= 1'b0;
        end else begin
            strobe_q    <= strobe_d;
            ready_q     <= (phase_d == PH_REST) && !busS;
            instrDone_q <= instrEnd;
            intSample_q <= instrEnd && intAllowed; // RL7
            busAck_q    <= (phase_d == PH_HOLD);
        end
    end

    assign rdN                  = strobe_q.rdN;
    assign wrN                  = strobe_q.wrN;
    assign memory_request_n     = strobe_q.memReqN;
    assign io_request_n         = strobe_q.ioReqN;
    assign opcode_fetch_cycle_n = strobe_q.fetchN;
    assign haltN                = strobe_q.haltN;
    assign first_fetch_status   = strobe_q.firstFetch;
    assign dataOe               = strobe_q.dataOe;
    assign instrReady           = ready_q;
    assign instrDone            = instrDone_q;
    assign intSample            = intSample_q;
    assign busAck               = busAck_q;

    // Idle states seen so far in the running instruction, for checking only
    logic [3:0] tiCount_q;
    wire  [3:0] tiCountNow = tiCount_q + 4'((phase_q == PH_TI) ? 1 : 0);
    always_ff @(posedge ref_clk) begin
        if (rst || startTake) tiCount_q <= 4'h0;
        else tiCount_q <= tiCountNow;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    fetch_first_a: assert property (startTake |=> !rdN && !memory_request_n // RL1
        && !opcode_fetch_cycle_n && !first_fetch_status && wrN && io_request_n)
        else $error("first cycle is not an opcode fetch");
    idle_release_a: assert property ((phase_q == PH_TI) |-> rdN && wrN // RL2
        && memory_request_n && io_request_n && opcode_fetch_cycle_n && haltN
        && first_fetch_status && !dataOe)
        else $error("strobes active during idle state");
    repeat_go_a: assert property (instrEnd && kind_q == K_CMPREP && !done_q // RL3
        |-> tiCountNow == 4'(IDLE_REP_GO))
        else $error("unfinished repeat compare idle count wrong");
    repeat_done_a: assert property (instrEnd && kind_q == K_CMPREP && done_q // RL4
        |-> tiCountNow == 4'(IDLE_REP_DONE))
        else $error("finished repeat compare idle count wrong");
    branch_taken_a: assert property (instrEnd && kind_q == K_DECREMENT_BRANCH_NONZERO // RL5
        |-> tiCountNow == (done_q ? 4'(IDLE_DECREMENT_BRANCH_NONZERO_DONE) : 4'(IDLE_DECREMENT_BRANCH_NONZERO_GO)))
        else $error("branch idle count wrong");
    branch_nogrant_a: assert property (ignore_q && phase_q != PH_REST // RL6
        |=> phase_q != PH_HOLD)
        else $error("bus granted inside branch");
    ei_nosample_a: assert property (instrEnd && kind_q == K_EI // RL7
        |=> !intSample && instrDone)
        else $error("interrupt sampled after enable");
    state_step_a: assert property ((phase_q == PH_T1) |=> (phase_q == PH_T2) // RL8
        ##1 (phase_q == PH_T2 || phase_q == PH_T3))
        else $error("bus states out of order");

    rep_go_c:    cover property (instrEnd && kind_q == K_CMPREP && !done_q);
    decrement_branch_nonzero_hold_c: cover property (ignore_q && busS);
    halt_exit_c: cover property (cycleEnd && haltExit);
    mid_hold_c:  cover property (cycleEnd && grantMid);

endmodule

/* File: bcs_pkg.sv */
// Shared types, constants and strobe decoding for the bus cycle sequencer
package bcs_pkg;

    typedef enum logic [3:0] {
        K_CPL, K_DAA, K_DI, K_EI, K_EXDE, K_EXAF, K_EXSPHL, K_EXSPIX,
        K_HALT, K_IM, K_INCG, K_INCHL, K_CMPBLK, K_CMPREP, K_DECREMENT_BRANCH_NONZERO
    } bcs_instr_t;

    typedef enum logic [2:0] {
        C_FETCH1, C_FETCH2, C_READ, C_WRITE, C_IDLE, C_HALTF, C_END
    } bcs_cycle_t;

    typedef struct packed {
        logic rdN;
        logic wrN;
        logic memReqN;
        logic ioReqN;
        logic fetchN;
        logic haltN;
        logic firstFetch;
        logic dataOe;
    } bcs_strobe_t;

    localparam int unsigned STEP_W         = 4;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned IDLE_CMP       = 3;
    localparam int unsigned IDLE_REP_GO    = 5;
    localparam int unsigned IDLE_REP_DONE  = 3;
    localparam int unsigned IDLE_DECREMENT_BRANCH_NONZERO_GO   = 3;
    localparam int unsigned IDLE_DECREMENT_BRANCH_NONZERO_DONE = 1;
    localparam logic [STEP_W-1:0] STEP_DECREMENT_BRANCH_NONZERO_TI = 4'h1;
    localparam bcs_strobe_t STROBE_REST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    function automatic bcs_strobe_t strobesOf(input bcs_cycle_t c);
        bcs_strobe_t s;
        s = STROBE_REST;
        case (c)
            C_FETCH1: begin
                s.rdN = 1'b0; s.memReqN = 1'b0; s.fetchN = 1'b0; s.firstFetch = 1'b0;
            end
            C_FETCH2: begin
                s.rdN = 1'b0; s.memReqN = 1'b0; s.fetchN = 1'b0;
            end
            C_READ: begin
                s.rdN = 1'b0; s.memReqN = 1'b0;
            end
            C_WRITE: begin
                s.wrN = 1'b0; s.memReqN = 1'b0; s.dataOe = 1'b1;
            end
            C_HALTF: begin
                s.rdN = 1'b0; s.memReqN = 1'b0; s.fetchN = 1'b0;
                s.haltN = 1'b0; s.firstFetch = 1'b0;
            end
            default: s = STROBE_REST;
        endcase
        return s;
    endfunction

endpackage

/* File: bcs_step_if.sv */
// Lookup channel between the sequencer and its step table
interface bcs_step_if;
    import bcs_pkg::*;
    bcs_instr_t        kind;
    logic [STEP_W-1:0] step;
    logic              done;
    bcs_cycle_t        cycle;
    modport seq_side   (output kind, output step, output done, input cycle);
    modport table_side (input kind, input step, input done, output cycle);
endinterface

/* File: bcs_step_table.sv */
// Machine cycle sequence of each instruction, indexed by step
module bcs_step_table
    import bcs_pkg::*;
(
    // Lookup
    bcs_step_if.table_side tbl
);

    logic [STEP_W-1:0] s;
    assign s = tbl.step;

    always_comb begin
        tbl.cycle = C_END;
        case (tbl.kind)
            K_CPL, K_DI, K_EI, K_EXDE: begin
                if (s == 4'h0) tbl.cycle = C_FETCH1; // RL1
            end
            K_DAA, K_EXAF, K_INCG: begin
                if (s == 4'h0) tbl.cycle = C_FETCH1;
                else if (s == 4'h1) tbl.cycle = C_IDLE;
            end
            K_IM: begin
                if (s == 4'h0) tbl.cycle = C_FETCH1;
                else if (s == 4'h1) tbl.cycle = C_FETCH2;
            end
            K_HALT: begin
                // Halt fetches repeat until the sequencer sees a resume
                tbl.cycle = (s == 4'h0) ? C_FETCH1 : C_HALTF;
            end
            K_INCHL: begin
                case (s)
                    4'h0:    tbl.cycle = C_FETCH1;
                    4'h1:    tbl.cycle = C_READ;
                    4'h2:    tbl.cycle = C_IDLE;
                    4'h3:    tbl.cycle = C_WRITE;
                    default: tbl.cycle = C_END;
                endcase
            end
            K_EXSPHL: begin
                case (s)
                    4'h0:       tbl.cycle = C_FETCH1;
                    4'h1, 4'h2: tbl.cycle = C_READ;
                    4'h3:       tbl.cycle = C_IDLE;
                    4'h4, 4'h5: tbl.cycle = C_WRITE;
                    default:    tbl.cycle = C_END;
                endcase
            end
            K_EXSPIX: begin
                case (s)
                    4'h0:       tbl.cycle = C_FETCH1;
                    4'h1:       tbl.cycle = C_FETCH2;
                    4'h2, 4'h3: tbl.cycle = C_READ;
                    4'h4:       tbl.cycle = C_IDLE;
                    4'h5, 4'h6: tbl.cycle = C_WRITE;
                    default:    tbl.cycle = C_END;
                endcase
            end
            K_CMPBLK, K_CMPREP: begin
                if (s == 4'h0) tbl.cycle = C_FETCH1;
                else if (s == 4'h1) tbl.cycle = C_FETCH2;
                else if (s == 4'h2) tbl.cycle = C_READ;
                else if (tbl.kind == K_CMPBLK && s < 4'(3 + IDLE_CMP)) tbl.cycle = C_IDLE;
                else if (tbl.kind == K_CMPREP && !tbl.done && s < 4'(3 + IDLE_REP_GO))
                    tbl.cycle = C_IDLE; // RL3
                else if (tbl.kind == K_CMPREP && tbl.done && s < 4'(3 + IDLE_REP_DONE))
                    tbl.cycle = C_IDLE; // RL4
            end
            K_DECREMENT_BRANCH_NONZERO: begin
                case (s)
                    4'h0:       tbl.cycle = C_FETCH1;
                    4'h1:       tbl.cycle = C_IDLE;
                    4'h2:       tbl.cycle = C_READ;
                    4'h3, 4'h4: tbl.cycle = tbl.done ? C_END : C_IDLE; // RL5
                    default:    tbl.cycle = C_END;
                endcase
            end
            default: tbl.cycle = C_END;
        endcase
    end

endmodule

/* File: bcs_bus_model.sv */
// Memory side model that answers promptly or with wait states
module bcs_bus_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Strobes from the sequencer
    input  wire logic rdN,
    input  wire logic memory_request_n,
    // Answer speed
    input  wire logic slow,
    // Wait pin
    output logic      waitReqN
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] waitCnt_q;
    wire        readActive = !rdN && !memory_request_n;

    // Wait is bounded per access so a stretched state always ends
    always_ff @(posedge ref_clk) begin
        if (rst || !readActive) begin
            waitCnt_q <= 3'h0;
            waitReqN  <= 1'b1;
        end else if (slow && waitCnt_q != 3'h6) begin
            waitCnt_q <= waitCnt_q + 3'h1;
            waitReqN  <= 1'b0;
        end else begin
            waitReqN  <= 1'b1;
        end
    end
endmodule

/* File: bus_cycle_sequencer_block_ops_tb.sv */
// Self-checking bench for the bus cycle sequencer
module bus_cycle_sequencer_block_ops_tb;
    import bcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       ref_clk = 1'b0;
    logic       rst, instrStart, instrFinish, busReq, resumeReq, slowBus;
    bcs_instr_t instrKind;
    logic       instrReady, instrDone, intSample, waitReqN, busAck;
    logic       rdN, wrN, memReqN, ioReqN, fetchN, haltN, firstFetch, dataOe;
    int         errors = 0;
    int         totalChecks = 0;
    int         cycles = 0;

    bcs_sequencer uut (
        .ref_clk(ref_clk), .rst(rst), .instrStart(instrStart), .instrKind(instrKind),
        .instrFinish(instrFinish), .instrReady(instrReady), .instrDone(instrDone),
        .intSample(intSample), .waitReqN(waitReqN), .busReq(busReq),
        .resumeReq(resumeReq), .rdN(rdN), .wrN(wrN), .memory_request_n(memReqN),
        .io_request_n(ioReqN), .opcode_fetch_cycle_n(fetchN), .haltN(haltN),
        .first_fetch_status(firstFetch), .dataOe(dataOe), .busAck(busAck)
    );

    bcs_bus_model mem (
        .ref_clk(ref_clk), .rst(rst), .rdN(rdN), .memory_request_n(memReqN),
        .slow(slowBus), .waitReqN(waitReqN)
    );

    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    // State class from the strobe pattern: F first fetch, G second fetch,
    // R read, W write, I idle, H halt fetch
    function automatic byte cls();
        case ({rdN, wrN, memReqN, ioReqN, fetchN, haltN, firstFetch, dataOe})
            8'h54: return "F";
            8'h56: return "G";
            8'h5e: return "R";
            8'h9f: return "W";
            8'hfe: return "I";
            8'h50: return "H";
            default: return "?";
        endcase
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic waitReady();
        int i;
        for (i = 0; i < 30 && instrReady !== 1'b1; i++) @(negedge ref_clk);
        check(instrReady, 1'b1);
    endtask

    task automatic waitAck(input logic lvl);
        int i;
        for (i = 0; i < 12 && busAck !== lvl; i++) @(negedge ref_clk);
        check(busAck, lvl);
    endtask

    // Runs one instruction; seq lists machine cycles, three states each except I
    task automatic runInstr(input bcs_instr_t k, input logic fin, input string seq,
                            input logic expInt, input int busAt);
        string e;
        byte   got [$];
        int    i, n;
        e = "";
        for (i = 0; i < seq.len(); i++) begin
            if (seq[i] == "I") e = {e, "I"};
            else e = {e, seq.substr(i, i), seq.substr(i, i), seq.substr(i, i)};
        end
        waitReady();
        instrKind   = k;
        instrFinish = fin;
        instrStart  = 1'b1;
        @(negedge ref_clk);
        instrStart = 1'b0;
        n = 0;
        while (instrDone !== 1'b1 && n < 60) begin
            got.push_back(cls());
            n++;
            if (n == busAt) busReq = 1'b1;
            check(busAck, 1'b0);
            @(negedge ref_clk);
        end
        check(instrDone, 1'b1);
        check(intSample, expInt);
        if (slowBus) begin
            check(n > e.len(), 1'b1);
            check(got[0], "F");
            check(got[n-1], e[e.len()-1]);
        end else begin
            check(n, e.len());
            for (i = 0; i < n && i < e.len(); i++) check(got[i], e[i]);
        end
        if (busAt > 0) begin
            waitAck(1'b1);
            busReq = 1'b0;
            waitAck(1'b0);
        end
    endtask

    task automatic testKinds();
        runInstr(K_CPL, 1'b0, "F", 1'b1, 0);
        runInstr(K_DAA, 1'b0, "FI", 1'b1, 0);
        runInstr(K_DI, 1'b0, "F", 1'b0, 0);
        runInstr(K_EI, 1'b0, "F", 1'b0, 0);
        runInstr(K_EXDE, 1'b0, "F", 1'b1, 0);
        runInstr(K_EXAF, 1'b0, "FI", 1'b1, 0);
        runInstr(K_EXSPHL, 1'b0, "FRRIWW", 1'b1, 0);
        runInstr(K_EXSPIX, 1'b0, "FGRRIWW", 1'b1, 0);
        runInstr(K_IM, 1'b0, "FG", 1'b1, 0);
        runInstr(K_INCG, 1'b0, "FI", 1'b1, 0);
        runInstr(K_INCHL, 1'b0, "FRIW", 1'b1, 0);
        runInstr(K_CMPBLK, 1'b0, "FGRIII", 1'b1, 0);
        runInstr(K_CMPREP, 1'b0, "FGRIIIII", 1'b1, 0);
        runInstr(K_CMPREP, 1'b1, "FGRIII", 1'b1, 0);
        runInstr(K_DECREMENT_BRANCH_NONZERO, 1'b0, "FIRII", 1'b1, 0);
        runInstr(K_DECREMENT_BRANCH_NONZERO, 1'b1, "FIR", 1'b1, 0);
        $display("test kinds done");
    endtask

    // Slow memory stretches the access instead of dropping a cycle
    task automatic testWait();
        slowBus = 1'b1;
        runInstr(K_IM, 1'b0, "FG", 1'b1, 0);
        slowBus = 1'b0;
        $display("test wait done");
    endtask

    task automatic testBusRest();
        waitReady();
        busReq = 1'b1;
        waitAck(1'b1);
        check(cls(), "I");
        check(instrReady, 1'b0);
        busReq = 1'b0;
        waitAck(1'b0);
        $display("test bus rest done");
    endtask

    // Request raised during the displacement read must wait for the boundary
    task automatic testDjnzHold();
        runInstr(K_DECREMENT_BRANCH_NONZERO, 1'b0, "FIRII", 1'b1, 5);
        $display("test branch hold done");
    endtask

    task automatic testHalt();
        int n;
        waitReady();
        instrKind  = K_HALT;
        instrStart = 1'b1;
        @(negedge ref_clk);
        instrStart = 1'b0;
        // Long enough that the halt fetches outlast the step counter's range
        for (n = 0; n < 60; n++) begin
            check(cls(), n < 3 ? "F" : "H");
            @(negedge ref_clk);
        end
        resumeReq = 1'b1;
        while (instrDone !== 1'b1 && n < 80) begin
            check(cls(), "H");
            n++;
            @(negedge ref_clk);
        end
        resumeReq = 1'b0;
        check(instrDone, 1'b1);
        check(intSample, 1'b1);
        check(n % 3, 0);
        $display("test halt done");
    endtask

    // Request seen during an idle state is granted there; the write resumes after release
    task automatic testMidHold();
        int n;
        waitReady();
        instrKind  = K_INCHL;
        instrStart = 1'b1;
        @(negedge ref_clk);
        instrStart = 1'b0;
        repeat (4) @(negedge ref_clk);
        busReq = 1'b1;
        waitAck(1'b1);
        check(cls(), "I");
        check(instrDone, 1'b0);
        busReq = 1'b0;
        waitAck(1'b0);
        check(cls(), "W");
        for (n = 0; n < 10 && instrDone !== 1'b1; n++) @(negedge ref_clk);
        check(instrDone, 1'b1);
        check(n, 3);
        $display("test mid hold done");
    endtask

    // Reset in mid-instruction releases every strobe and the next instruction starts clean
    task automatic testReset();
        waitReady();
        instrKind   = K_CMPREP;
        instrFinish = 1'b0;
        instrStart  = 1'b1;
        @(negedge ref_clk);
        instrStart = 1'b0;
        repeat (4) @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        check(cls(), "I");
        check({instrReady, instrDone, busAck}, 3'h0);
        runInstr(K_CMPREP, 1'b0, "FGRIIIII", 1'b1, 0);
        $display("test reset done");
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        rst         = 1'b1;
        instrStart  = 1'b0;
        instrKind   = K_CPL;
        instrFinish = 1'b0;
        busReq      = 1'b0;
        resumeReq   = 1'b0;
        slowBus     = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        testKinds();
        testWait();
        testBusRest();
        testDjnzHold();
        testHalt();
        testMidHold();
        testReset();
        test_done();
    end
endmodule
